// ===== src/period_timer_map.vh
// period_timer_map.vh: register offsets, field positions, reset values and divider codes
// assumes a 32-bit classic wishbone slave with word-aligned byte addresses
`ifndef PERIOD_TIMER_MAP_VH
`define PERIOD_TIMER_MAP_VH

// register byte offsets
`define OFS_CONTROL       4'h0
`define OFS_COUNTER       4'h4
`define OFS_LIMIT         4'h8
`define OFS_IRQ_STATUS    4'hc

// register index bits taken from the wishbone address
`define ADR_HI            3
`define ADR_LO            2

// control register fields
`define CTL_WRITE_MASK    8'h7f
`define CTL_RUN_BIT       2
`define CTL_POST_HI       6
`define CTL_POST_LO       3
`define CTL_PRE_HI        1
`define CTL_PRE_LO        0

// reset values
`define RST_CONTROL       8'h00
`define RST_COUNTER       8'h00
`define RST_LIMIT         8'hff

// irq status/mask register layout: bit 0 flag, bit 8 enable
`define IRQ_FLAG_BIT      0
`define IRQ_ENABLE_BIT    8

// instruction clock: divider count at which the enable fires, once per four system clocks
`define INSTR_DIV         2'd3

// prescaler terminal counts (ratio minus one)
`define PRE_DIV1          6'h00
`define PRE_DIV4          6'h03
`define PRE_DIV16         6'h0f
`define PRE_DIV64         6'h3f

`endif

// ===== src/period_prescaler.v
// period_prescaler.v: instruction-clock divider and selectable prescaler
// derives its own one-cycle tick at the instruction rate from quarter_reg
`timescale 1ns/1ns
`default_nettype none
`include "period_timer_map.vh"

module period_prescaler (
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // control
    input  wire       clear_i,
    input  wire       run_i,
    input  wire [1:0] select_i,
    // timer step enable
    output reg        step_o
);

    reg  [1:0] quarter_reg;
    reg  [5:0] count_reg;
    reg  [5:0] terminal;
    wire       tick;

    always @* begin
        case (select_i)
            2'b00:   terminal = `PRE_DIV1;
            2'b01:   terminal = `PRE_DIV4;
            2'b10:   terminal = `PRE_DIV16;
            default: terminal = `PRE_DIV64;
        endcase
    end

    // instruction clock is one quarter of the system clock
    assign tick = (quarter_reg == `INSTR_DIV);

    always @(posedge clk_i) begin
        if (rst_i) begin
            quarter_reg <= 2'd0;
            count_reg   <= 6'h00;
            step_o      <= 1'b0;
        end else begin
            quarter_reg <= quarter_reg + 2'd1;
            step_o      <= 1'b0;
            if (clear_i) begin
                count_reg <= 6'h00;
            end else if (run_i && tick) begin
                if (count_reg >= terminal) begin
                    count_reg <= 6'h00;
                    step_o    <= 1'b1;
                end else begin
                    count_reg <= count_reg + 6'h01;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ===== src/period_postscaler.v
// period_postscaler.v: 4-bit match postscaler
// assumes match_i is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none

module period_postscaler (
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // control
    input  wire       clear_i,
    input  wire [3:0] select_i,
    input  wire       match_i,
    // terminal count pulse
    output reg        event_o
);

    reg [3:0] count_reg;

    always @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= 4'h0;
            event_o   <= 1'b0;
        end else begin
            event_o <= 1'b0;
            if (clear_i) begin
                count_reg <= 4'h0;
            end else if (match_i) begin
                if (count_reg == select_i) begin
                    count_reg <= 4'h0;
                    event_o   <= 1'b1;
                end else begin
                    count_reg <= count_reg + 4'h1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ===== src/period_match_timer.v
// period_match_timer.v: 8-bit period-match timer with prescaler and postscaler
// assumes a classic wishbone master on clk_i and a sleep level from the core
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
`include "period_timer_map.vh"

module period_match_timer #(
    parameter SPI_CLOCK_SOURCE = 1
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [3:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // core state
    input  wire        sleep_i,
    // timer outputs
    output reg         match_o,
    output reg         spi_clk_o,
    output reg         irq_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    reg  [7:0] period_timer_control_reg;
    reg  [7:0] period_counter_reg;
    reg  [7:0] period_limit_reg;
    reg        match_irq_flag_reg;
    reg        match_irq_enable_reg;
    reg        match_reg;
    wire       step;
    wire       post_event;
    wire       access;
    wire       wr;
    wire       rd;
    wire       sel_lo;
    wire       wr_ctl;
    wire       wr_cnt;
    wire       wr_lim;
    wire       wr_irq;
    wire       rd_irq;
    wire       scaler_clear;
    wire       running;
    reg  [31:0] read_data;

    function is_reg;
        input [3:0] adr;
        input [3:0] ofs;
        begin
            is_reg = (adr[`ADR_HI:`ADR_LO] == ofs[`ADR_HI:`ADR_LO]);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode

    assign access = cyc_i && stb_i && !ack_o;
    assign wr     = access && we_i;
    assign rd     = access && !we_i;
    assign sel_lo = sel_i[0];
    assign wr_ctl = wr && sel_lo && is_reg(adr_i, `OFS_CONTROL);
    assign wr_cnt = wr && sel_lo && is_reg(adr_i, `OFS_COUNTER);
    assign wr_lim = wr && sel_lo && is_reg(adr_i, `OFS_LIMIT);
    assign wr_irq = wr && is_reg(adr_i, `OFS_IRQ_STATUS);
    assign rd_irq = rd && is_reg(adr_i, `OFS_IRQ_STATUS);

    assign scaler_clear = wr_ctl || wr_cnt;
    // sleep freezes counting without touching any register
    assign running = period_timer_control_reg[`CTL_RUN_BIT] && !sleep_i;

    always @* begin
        read_data = 32'h0000_0000;
        case (adr_i[`ADR_HI:`ADR_LO])
            2'd0: read_data[7:0] = period_timer_control_reg & `CTL_WRITE_MASK;
            2'd1: read_data[7:0] = period_counter_reg;
            2'd2: read_data[7:0] = period_limit_reg;
            default: begin
                read_data[`IRQ_FLAG_BIT]   = match_irq_flag_reg;
                read_data[`IRQ_ENABLE_BIT] = match_irq_enable_reg;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= access;
            if (rd) begin
                dat_o <= read_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // scalers

    period_prescaler u_pre (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .clear_i  (scaler_clear),
        .run_i    (running),
        .select_i (period_timer_control_reg[`CTL_PRE_HI:`CTL_PRE_LO]),
        .step_o   (step)
    );

    period_postscaler u_post (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .clear_i  (scaler_clear),
        .select_i (period_timer_control_reg[`CTL_POST_HI:`CTL_POST_LO]),
        .match_i  (match_reg),
        .event_o  (post_event)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // counter, limit and control

    always @(posedge clk_i) begin
        if (rst_i) begin
            period_timer_control_reg <= `RST_CONTROL;
            period_counter_reg       <= `RST_COUNTER;
            period_limit_reg         <= `RST_LIMIT;
            match_reg                <= 1'b0;
        end else begin
            match_reg <= 1'b0;
            if (wr_ctl) begin
                period_timer_control_reg <= dat_i[7:0] & `CTL_WRITE_MASK;
            end
            if (wr_lim) begin
                period_limit_reg <= dat_i[7:0];
            end
            if (wr_cnt) begin
                period_counter_reg <= dat_i[7:0];
            end else if (running && step) begin
                if (period_counter_reg == period_limit_reg) begin
                    period_counter_reg <= 8'h00;
                    match_reg          <= 1'b1;
                end else begin
                    period_counter_reg <= period_counter_reg + 8'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt and outputs

    always @(posedge clk_i) begin
        if (rst_i) begin
            match_irq_flag_reg   <= 1'b0;
            match_irq_enable_reg <= 1'b0;
        end else begin
            if (post_event) begin
                match_irq_flag_reg <= 1'b1;
            end else if (rd_irq) begin
                match_irq_flag_reg <= 1'b0;
            end
            if (wr_irq && sel_i[1]) begin
                match_irq_enable_reg <= dat_i[`IRQ_ENABLE_BIT];
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            match_o   <= 1'b0;
            spi_clk_o <= 1'b0;
            irq_o     <= 1'b0;
        end else begin
            match_o   <= match_reg;
            spi_clk_o <= (SPI_CLOCK_SOURCE != 0) && match_reg;
            irq_o     <= (match_irq_flag_reg || post_event) && match_irq_enable_reg;
        end
    end

endmodule
`default_nettype wire

// ===== sim/period_match_timer_props.sv
// period_match_timer_props.sv: port-level assertions for the period-match timer
// assumes the top module's ports as declared; attached with bind below
`timescale 1ns/1ns
`default_nettype none

module period_match_timer_props #(
    parameter SPI_CLOCK_SOURCE = 1
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [3:0]  adr_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        sleep_i,
    input wire logic        match_o,
    input wire logic        spi_clk_o,
    input wire logic        irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered next cycle");
    chk_spi_follow: assert property (spi_clk_o == (SPI_CLOCK_SOURCE != 0 && match_o))
        else $error("shift clock differs from match");
    chk_match_gap: assert property (match_o |=> !match_o [*3])
        else $error("matches closer than one instruction tick");
    chk_sleep_freeze: assert property (sleep_i [*5] |-> !match_o)
        else $error("match during sleep");
    chk_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && !irq_o && !match_o)
        else $error("outputs active after reset");
    chk_read_upper: assert property (ack_o && !we_i |-> dat_o[31:9] == 23'h0)
        else $error("read data upper bits not zero");
    chk_ctl_bit7: assert property (ack_o && !we_i && adr_i == 4'h0 |-> !dat_o[7])
        else $error("control bit 7 reads one");

    cov_match: cover property (match_o);
    cov_irq: cover property ($rose(irq_o));
    cov_write: cover property (ack_o && we_i);
endmodule

bind period_match_timer period_match_timer_props #(.SPI_CLOCK_SOURCE(SPI_CLOCK_SOURCE)) props_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .dat_o(dat_o), .ack_o(ack_o), .sleep_i(sleep_i), .match_o(match_o),
    .spi_clk_o(spi_clk_o), .irq_o(irq_o));
`default_nettype wire

// ===== sim/period_match_sink.sv
// period_match_sink.sv: pwm time base and spi shifter standing on the match outputs
// assumes match_i and spi_clk_i are one-cycle pulses on clk_i
`timescale 1ns/1ns
`default_nettype none

module period_match_sink (
    input wire logic         clk_i,
    input wire logic         rst_i,
    input wire logic         match_i,
    input wire logic         spi_clk_i,
    output var logic [15:0]  count_o,
    output var logic [15:0]  gap_o,
    output var logic [15:0]  shifts_o
);
    logic [15:0] since;
    always @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= 16'h0;
            gap_o <= 16'h0;
            shifts_o <= 16'h0;
            since <= 16'h0;
        end else begin
            since <= since + 16'h1;
            // pwm period restarts on every match
            if (match_i) begin
                count_o <= count_o + 16'h1;
                gap_o <= since + 16'h1;
                since <= 16'h0;
            end
            if (spi_clk_i) shifts_o <= shifts_o + 16'h1;
        end
    end
endmodule
`default_nettype wire

// ===== sim/period_match_timer_test.sv
// period_match_timer_test.sv: self-checking bench for the period-match timer
// assumes the register map header and the sink model
`timescale 1ns/1ns
`default_nettype none
`include "period_timer_map.vh"

module period_match_timer_test;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, sleep_i = 0;
    logic [3:0]  adr_i = 0, sel_i = 4'hf;
    logic [31:0] dat_i = 0, dat_o, rd, c0, lim, post;
    logic        ack_o, match_o, spi_clk_o, irq_o;
    logic [15:0] n_match, gap, shifts;
    int          miscompares = 0, tests_run = 0, cycles = 0, p;
    int          seed = 32'h5b5dfd9c;

    period_match_timer #(.SPI_CLOCK_SOURCE(1)) period_match_timer_inst (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .sleep_i(sleep_i), .match_o(match_o), .spi_clk_o(spi_clk_o), .irq_o(irq_o));
    period_match_sink period_match_sink_inst (
        .clk_i(clk_i), .rst_i(rst_i), .match_i(match_o), .spi_clk_i(spi_clk_o),
        .count_o(n_match), .gap_o(gap), .shifts_o(shifts));

    initial forever #5 clk_i = ~clk_i;

    function automatic logic [31:0] period(input logic [31:0] l, input int ps);
        return (l + 1) * 4 * (1 << (2 * ps));
    endfunction

    task close_out;
        if (miscompares == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %0t got %h want %h", $time, got, exp);
        end
    endtask

    // one classic cycle, held until ack is sampled
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 0; stb_i <= 0; we_i <= 0;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            close_out;
        end
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        bus(0, `OFS_CONTROL, 0); cmp(rd, 32'h0);
        bus(0, `OFS_COUNTER, 0); cmp(rd, 32'h0);
        bus(0, `OFS_LIMIT, 0); cmp(rd, 32'hff);
        bus(1, `OFS_CONTROL, 32'hff); bus(0, `OFS_CONTROL, 0); cmp(rd, 32'h7f);
        for (p = 0; p < 4; p++) begin
            lim = $random(seed) & 3;
            bus(1, `OFS_LIMIT, lim); bus(1, `OFS_COUNTER, 0); bus(1, `OFS_CONTROL, 4 + p);
            c0 = n_match;
            while (n_match < c0 + 3) @(posedge clk_i);
            cmp({16'h0, gap}, period(lim, p));
        end
        bus(1, `OFS_CONTROL, 0); bus(0, `OFS_COUNTER, 0); c0 = rd;
        repeat (300) @(posedge clk_i);
        bus(0, `OFS_COUNTER, 0); cmp(rd, c0);
        bus(1, `OFS_CONTROL, 32'h7c); sleep_i <= 1;
        repeat (300) @(posedge clk_i);
        bus(0, `OFS_COUNTER, 0); cmp(rd, c0);
        bus(0, `OFS_LIMIT, 0); cmp(rd, lim);
        sleep_i <= 0;
        bus(1, `OFS_LIMIT, 0); bus(1, `OFS_CONTROL, 5);
        bus(1, `OFS_COUNTER, 0); c0 = n_match;
        // counter writes every third cycle keep the divide-by-4 prescaler from stepping
        repeat (20) bus(1, `OFS_COUNTER, 0);
        cmp(n_match - c0, 0);
        bus(1, `OFS_IRQ_STATUS, 0); bus(1, `OFS_CONTROL, 4);
        repeat (40) @(posedge clk_i);
        cmp(irq_o, 0);
        bus(1, `OFS_CONTROL, 0); bus(0, `OFS_IRQ_STATUS, 0); cmp(rd, 32'h1);
        bus(0, `OFS_IRQ_STATUS, 0); cmp(rd, 32'h0);
        for (p = 0; p < 4; p++) begin
            post = (p == 0) ? 0 : (p == 1) ? 15 : $random(seed) & 15;
            bus(1, `OFS_IRQ_STATUS, 32'h100); bus(1, `OFS_CONTROL, post << 3);
            bus(0, `OFS_IRQ_STATUS, 0); bus(1, `OFS_CONTROL, (post << 3) + 4);
            c0 = n_match;
            while (irq_o !== 1'b1) @(posedge clk_i);
            cmp(n_match - c0, post + 1);
            bus(1, `OFS_CONTROL, 0); bus(0, `OFS_IRQ_STATUS, 0); cmp(rd, 32'h101);
            repeat (3) @(posedge clk_i);
            cmp(irq_o, 0);
        end
        cmp(shifts, n_match);
        close_out;
    end
endmodule
`default_nettype wire
